// ===== serial_status_flag_logic.sv
/*
 Status flag logic of the serial port: status register, control bits,
 interrupt status/mask and the flag events from the shift engines.
 Assumes: shift engines give one-cycle event pulses on sys_clk with side
 bits valid in the same cycle; register port strobes are one cycle long.
*/
// Operation
// RULE1 - Transmit-empty set when disabled or byte moved
// RULE2 - Transmit-empty clears by read-1 then write-0
// RULE3 - Receive-full set on good reception
// RULE4 - Receive-full clears by read-1 then write-0
// RULE5 - Receive-full unchanged when receiver disabled
// RULE6 - Overrun set on receive while full
// RULE7 - Framing error set on zero stop bit
// RULE8 - Only the first stop bit checked
// RULE9 - Parity error set on parity mismatch
// RULE10 - Transmit-end read-only, set, cleared with empty
// RULE11 - Received address bit captured, held when disabled
// RULE12 - Address bit to send from bit zero
// RULE13 - Writing one never sets a flag
// RULE14 - Address filter skips zero-bit characters
// RULE15 - Transmit-end request gated by its enable
// RULE16 - Transmit and receive gated by enables
module serial_status_flag_logic
    import sspf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic txLoad,
    input wire logic txLastBit,
    input wire logic rxDone,
    input wire logic rxAddrBit,
    input wire logic rxFirstStop,
    input wire logic rxParityBad,
    output logic txEnable,
    output logic rxEnable,
    output logic txAddrBit,
    output logic txHoldingFull,
    output logic txDoneIrq,
    output logic irq
);
    typedef struct packed {
        logic [7:0] status;
        logic [4:0] control;
        logic [SSPF_IRQ_W-1:0] irqStat;
        logic [SSPF_IRQ_W-1:0] irqMask;
        logic [7:0] rdData;
    } sspf_state_t;
    sspf_state_t st_r, st_nxt;

    logic rdStatus;
    logic wrStatus;
    logic [4:0] clearReq;
    logic accept;
    logic filterRelease;
    logic filterOn;
    logic rxEv;
    logic txLoadEv;
    logic txLastEv;

    assign rdStatus = regRdStb && (regAddr == SSPF_ADDR_STATUS);
    assign wrStatus = regWrStb && (regAddr == SSPF_ADDR_STATUS);
    assign filterOn = st_r.control[SSPF_CTL_AFEN] && st_r.control[SSPF_CTL_MPMODE];
    assign rxEv = rxDone && st_r.control[SSPF_CTL_RXEN]; // RULE16
    assign txLoadEv = txLoad && st_r.control[SSPF_CTL_TXEN]; // RULE16
    assign txLastEv = txLastBit && st_r.control[SSPF_CTL_TXEN]; // RULE16

    sspf_clear_arm #(
        .W(5)
    ) u_clear (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .flagNow(st_r.status[7:3]),
        .rdSeen(rdStatus),
        .wrSeen(wrStatus),
        .wrData(regWrData[7:3]),
        .clearReq(clearReq)
    );

    sspf_rx_decide u_rxdec (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .rxDone(rxEv),
        .rxAddrBit(rxAddrBit),
        .filterOn(filterOn),
        .accept(accept),
        .skip(),
        .filterRelease(filterRelease)
    );

    always_comb begin
        logic [7:0] s;
        logic tdeSet;
        logic rdfSet;
        logic ovrSet;
        logic frmSet;
        logic parSet;
        logic tcoSet;
        logic [SSPF_IRQ_W-1:0] ev;
        s = st_r.status;
        ev = '0;
        {tdeSet, rdfSet, ovrSet, frmSet, parSet, tcoSet} = 6'h00;
        st_nxt = st_r;

        // Clears first so that a same-cycle set wins
        if (clearReq[4]) begin
            s[SSPF_BIT_TDE] = 1'b0; // RULE2
            s[SSPF_BIT_TCO] = 1'b0; // RULE10
        end
        if (clearReq[3]) begin
            s[SSPF_BIT_RDF] = 1'b0; // RULE4
        end
        if (clearReq[2]) begin
            s[SSPF_BIT_OVR] = 1'b0; // RULE6
        end
        if (clearReq[1]) begin
            s[SSPF_BIT_FRM] = 1'b0; // RULE7
        end
        if (clearReq[0]) begin
            s[SSPF_BIT_PAR] = 1'b0; // RULE9
        end

        tdeSet = !st_r.control[SSPF_CTL_TXEN] || txLoadEv; // RULE1
        tcoSet = !st_r.control[SSPF_CTL_TXEN] || (txLastEv && st_r.status[SSPF_BIT_TDE]); // RULE10
        // Stop check uses only the first stop bit; a second one is never looked at
        frmSet = accept && !rxFirstStop; // RULE7 RULE8
        ovrSet = accept && st_r.status[SSPF_BIT_RDF]; // RULE6
        rdfSet = accept && rxFirstStop && !rxParityBad && !st_r.status[SSPF_BIT_RDF]; // RULE3
        parSet = accept && rxParityBad; // RULE9
        if (tdeSet) begin
            s[SSPF_BIT_TDE] = 1'b1;
        end
        if (tcoSet) begin
            s[SSPF_BIT_TCO] = 1'b1;
        end
        if (rdfSet) begin
            s[SSPF_BIT_RDF] = 1'b1;
        end
        if (ovrSet) begin
            s[SSPF_BIT_OVR] = 1'b1;
        end
        if (frmSet) begin
            s[SSPF_BIT_FRM] = 1'b1;
        end
        if (parSet) begin
            s[SSPF_BIT_PAR] = 1'b1;
        end
        // Receiver disable leaves receive-full and address bit alone
        if (accept) begin
            s[SSPF_BIT_ARX] = rxAddrBit; // RULE11 RULE5
        end
        if (wrStatus) begin
            s[SSPF_BIT_ATX] = regWrData[SSPF_BIT_ATX]; // RULE12 RULE13
        end
        st_nxt.status = s;

        if (regWrStb && regAddr == SSPF_ADDR_CONTROL) begin
            st_nxt.control = regWrData[4:0];
        end
        if (filterRelease) begin
            st_nxt.control[SSPF_CTL_AFEN] = 1'b0; // RULE14
        end

        ev[SSPF_IRQ_TDE] = txLoadEv;
        ev[SSPF_IRQ_RDF] = rdfSet;
        ev[SSPF_IRQ_ERR] = ovrSet || frmSet || parSet;
        ev[SSPF_IRQ_TCO] = txLastEv && st_r.status[SSPF_BIT_TDE];
        if (regWrStb && regAddr == SSPF_ADDR_IRQ_STAT) begin
            st_nxt.irqStat = st_r.irqStat & ~regWrData[SSPF_IRQ_W-1:0];
        end
        st_nxt.irqStat = st_nxt.irqStat | ev;
        if (regWrStb && regAddr == SSPF_ADDR_IRQ_MASK) begin
            st_nxt.irqMask = regWrData[SSPF_IRQ_W-1:0];
        end

        st_nxt.rdData = 8'h00;
        if (regRdStb) begin
            case (regAddr)
                SSPF_ADDR_STATUS: begin
                    st_nxt.rdData = st_r.status;
                end
                SSPF_ADDR_CONTROL: begin
                    st_nxt.rdData = {3'h0, st_r.control};
                end
                SSPF_ADDR_IRQ_STAT: begin
                    st_nxt.rdData = {4'h0, st_r.irqStat};
                end
                SSPF_ADDR_IRQ_MASK: begin
                    st_nxt.rdData = {4'h0, st_r.irqMask};
                end
                default: begin
                    st_nxt.rdData = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{status: SSPF_STATUS_RESET, control: SSPF_CONTROL_RESET,
                      irqStat: '0, irqMask: '0, rdData: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign regRdData = st_r.rdData;
    assign txEnable = st_r.control[SSPF_CTL_TXEN];
    assign rxEnable = st_r.control[SSPF_CTL_RXEN];
    assign txAddrBit = st_r.status[SSPF_BIT_ATX];
    assign txHoldingFull = !st_r.status[SSPF_BIT_TDE];
    // Request follows the flag level, so it drops with the clear sequence
    assign txDoneIrq = st_r.status[SSPF_BIT_TCO] && st_r.control[SSPF_CTL_TDIE]; // RULE15
    assign irq = |(st_r.irqStat & st_r.irqMask);
endmodule

// ===== serial_status_flag_logic_tb_top.sv
/*
 Bench for the serial status flag logic with a register-level model.
 Assumes: sspf_partner_model drives the engine events.
*/
module serial_status_flag_logic_tb_top
    import sspf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic [7:0] regRdData;
    logic txLoad, txLastBit, rxDone, rxAddrBit, rxFirstStop, rxParityBad;
    logic txEnable, rxEnable, txAddrBit, txHoldingFull, txDoneIrq, irq;
    int error_cnt = 0;
    int samples_checked = 0;
    logic [7:0] mSt = 8'h84, mCtl = 8'h00, mIst = 8'h00, mMsk = 8'h00, mArm = 8'h00;
    always #20 sys_clk = ~sys_clk;
    serial_status_flag_logic dut (.*);
    sspf_partner_model pm (.*);
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr_model(input logic [1:0] a, input logic [7:0] d);
        case (a)
            SSPF_ADDR_STATUS: begin
                mSt = mSt & ~(mArm & ~d & SSPF_CLEARABLE);
                if (mArm[7] && !d[7]) mSt[2] = 1'b0;
                mSt[0] = d[0];
                mArm = 8'h00;
            end
            SSPF_ADDR_CONTROL: mCtl = d & 8'h1F;
            SSPF_ADDR_IRQ_STAT: mIst = mIst & ~d;
            default: mMsk = d & 8'h0F;
        endcase
        if (!mCtl[0]) mSt = mSt | 8'h84;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        wr_model(a, d);
    endtask
    // Two status writes on consecutive edges: the first one disarms the second
    task automatic wr_pair(input logic [7:0] d1, input logic [7:0] d2);
        @(posedge sys_clk);
        regWrStb <= 1'b1;
        regAddr <= SSPF_ADDR_STATUS;
        regWrData <= d1;
        @(posedge sys_clk);
        regWrData <= d2;
        wr_model(SSPF_ADDR_STATUS, d1);
        @(posedge sys_clk);
        regWrStb <= 1'b0;
        wr_model(SSPF_ADDR_STATUS, d2);
    endtask
    task automatic rd(input logic [1:0] a);
        logic [7:0] e;
        @(posedge sys_clk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1;
        e = (a == 2'h0) ? mSt : (a == 2'h1) ? mCtl : (a == 2'h2) ? mIst : mMsk;
        check($sformatf("reg%0d", a), regRdData, e);
        check("pins", {2'h0, irq, txDoneIrq, txHoldingFull, txAddrBit, rxEnable, txEnable},
            {2'h0, |(mIst & mMsk), mSt[2] & mCtl[3], !mSt[7], mSt[0], mCtl[1:0]});
        if (a == 2'h0) mArm = mSt;
    endtask
    task automatic tx();
        pm.tx_char();
        if (mCtl[0]) begin
            mSt = mSt | 8'h84;
            mIst = mIst | 8'h09;
        end
    endtask
    task automatic rx(input logic a, input logic s, input logic p);
        logic ov;
        pm.rx_char(a, s, p);
        if (mCtl[1] && !(mCtl[2] && mCtl[4] && !a)) begin
            ov = mSt[6];
            mCtl[2] = 1'b0;
            if (!s) mSt[4] = 1'b1;
            if (p) mSt[3] = 1'b1;
            if (ov) mSt[5] = 1'b1;
            else if (s && !p) mSt[6] = 1'b1;
            if (!ov && s && !p) mIst[1] = 1'b1;
            if (ov || !s || p) mIst[2] = 1'b1;
            mSt[1] = a;
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #2000000;
        error_cnt++;
        final_report();
    end
    initial begin
        void'($urandom(32'h58D1688D));
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 4; i++) rd(i[1:0]);
        wr(SSPF_ADDR_CONTROL, 8'h03);
        wr(SSPF_ADDR_STATUS, 8'h00);
        rd(SSPF_ADDR_STATUS);
        wr(SSPF_ADDR_STATUS, 8'hFF);
        rd(SSPF_ADDR_STATUS);
        tx();
        wr(SSPF_ADDR_STATUS, 8'h00);
        rd(SSPF_ADDR_STATUS);
        wr_pair(8'hF8, 8'h00);
        rd(SSPF_ADDR_STATUS);
        $display("test tx flags done");
        wr(SSPF_ADDR_IRQ_MASK, 8'h06);
        rx(1'b1, 1'b1, 1'b0);
        rx(1'b0, 1'b1, 1'b0);
        rd(SSPF_ADDR_IRQ_STAT);
        for (int i = 0; i < 12; i++) begin
            rx(1'($urandom), 1'($urandom), 1'($urandom));
            rd(SSPF_ADDR_STATUS);
            if (i % 3 == 2) wr(SSPF_ADDR_STATUS, {7'h00, mSt[0]});
        end
        wr(SSPF_ADDR_IRQ_STAT, 8'hFF);
        rd(SSPF_ADDR_IRQ_STAT);
        $display("test rx flags done");
        wr(SSPF_ADDR_CONTROL, 8'h01);
        rx(~mSt[1], 1'b0, 1'b1);
        rd(SSPF_ADDR_STATUS);
        wr(SSPF_ADDR_CONTROL, 8'h17);
        rx(1'b0, 1'b1, 1'b0);
        rd(SSPF_ADDR_CONTROL);
        rx(1'b1, 1'b1, 1'b0);
        rd(SSPF_ADDR_CONTROL);
        rd(SSPF_ADDR_STATUS);
        $display("test filter done");
        wr(SSPF_ADDR_CONTROL, 8'h09);
        tx();
        rd(SSPF_ADDR_STATUS);
        wr(SSPF_ADDR_CONTROL, 8'h00);
        rd(SSPF_ADDR_STATUS);
        $display("test done request done");
        final_report();
    end
endmodule

// ===== sspf_clear_arm.sv
/*
 Per-flag read-then-write clear qualifier for the clearable status flags.
 Assumes: rdSeen pulses when software reads the status register.
*/
module sspf_clear_arm
    import sspf_pkg::*;
#(
    parameter int W = 5
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] flagNow,
    input wire logic rdSeen,
    input wire logic wrSeen,
    input wire logic [W-1:0] wrData,
    output logic [W-1:0] clearReq
);
    typedef struct packed {
        logic [W-1:0] armed;
    } sspf_arm_t;
    sspf_arm_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        clearReq = '0;
        for (int i = 0; i < W; i++) begin
            // Only a write of 0 after reading 1 clears; writing 1 does nothing
            if (wrSeen && st_r.armed[i] && !wrData[i]) begin // RULE2 RULE4 RULE13
                clearReq[i] = 1'b1;
            end
            if (wrSeen) begin
                st_nxt.armed[i] = 1'b0;
            end
            if (rdSeen) begin
                st_nxt.armed[i] = flagNow[i];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ===== sspf_partner_model.sv
/*
 Shift engine and line partner: gives the event pulses of frames.
 Assumes: tasks are called from the bench right after a rising edge.
*/
module sspf_partner_model (
    input wire logic sys_clk,
    output logic txLoad,
    output logic txLastBit,
    output logic rxDone,
    output logic rxAddrBit,
    output logic rxFirstStop,
    output logic rxParityBad
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {txLoad, txLastBit, rxDone, rxAddrBit, rxFirstStop, rxParityBad} = 6'h00;
    end
    task automatic tx_char();
        @(posedge sys_clk);
        txLoad <= 1'b1;
        @(posedge sys_clk);
        txLoad <= 1'b0;
        repeat (3) @(posedge sys_clk);
        txLastBit <= 1'b1;
        @(posedge sys_clk);
        txLastBit <= 1'b0;
    endtask
    // Only the first stop bit is reported; side bits turn over once stale
    task automatic rx_char(input logic a, input logic s, input logic p);
        @(posedge sys_clk);
        {rxDone, rxAddrBit, rxFirstStop, rxParityBad} <= {1'b1, a, s, p};
        @(posedge sys_clk);
        {rxDone, rxAddrBit, rxFirstStop, rxParityBad} <= {1'b0, ~a, ~s, ~p};
    endtask
endmodule

// ===== sspf_pkg.sv
/*
 Package for the serial status flag logic: register offsets, bit positions,
 reset values and the frame-event state encoding.
 Assumes: included before all design files of this block.
*/
package sspf_pkg;
    localparam logic [1:0] SSPF_ADDR_STATUS = 2'h0;
    localparam logic [1:0] SSPF_ADDR_CONTROL = 2'h1;
    localparam logic [1:0] SSPF_ADDR_IRQ_STAT = 2'h2;
    localparam logic [1:0] SSPF_ADDR_IRQ_MASK = 2'h3;

    localparam int SSPF_BIT_TDE = 7;
    localparam int SSPF_BIT_RDF = 6;
    localparam int SSPF_BIT_OVR = 5;
    localparam int SSPF_BIT_FRM = 4;
    localparam int SSPF_BIT_PAR = 3;
    localparam int SSPF_BIT_TCO = 2;
    localparam int SSPF_BIT_ARX = 1;
    localparam int SSPF_BIT_ATX = 0;

    localparam int SSPF_CTL_TXEN = 0;
    localparam int SSPF_CTL_RXEN = 1;
    localparam int SSPF_CTL_AFEN = 2;
    localparam int SSPF_CTL_TDIE = 3;
    localparam int SSPF_CTL_MPMODE = 4;

    localparam logic [7:0] SSPF_STATUS_RESET = 8'h84;
    localparam logic [7:0] SSPF_CLEARABLE = 8'hF8;
    localparam logic [4:0] SSPF_CONTROL_RESET = 5'h00;

    // Interrupt status bits
    localparam int SSPF_IRQ_TDE = 0;
    localparam int SSPF_IRQ_RDF = 1;
    localparam int SSPF_IRQ_ERR = 2;
    localparam int SSPF_IRQ_TCO = 3;
    localparam int SSPF_IRQ_W = 4;

    typedef enum logic [1:0] {
        SSPF_RX_IDLE = 2'b00,
        SSPF_RX_ACCEPT = 2'b01,
        SSPF_RX_SKIP = 2'b11
    } sspf_rxdec_t;
endpackage

// ===== sspf_properties.sv
/*
 Checker for the serial status flag logic, bound to its top module.
 Assumes: one sys_clk domain, reset_n asynchronous and active low.
*/
module sspf_chk
    import sspf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic txLoad,
    input wire logic txEnable,
    input wire logic rxEnable,
    input wire logic txAddrBit,
    input wire logic txHoldingFull,
    input wire logic txDoneIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic stWr;
    logic ctlWr;
    assign stWr = regWrStb && regAddr == SSPF_ADDR_STATUS;
    assign ctlWr = regWrStb && regAddr == SSPF_ADDR_CONTROL;
    chk_load_empties: assert property (txLoad && txEnable |=> !txHoldingFull)
        else $error("load did not empty holding");
    chk_off_empty: assert property (!txEnable && !$past(txEnable) |-> !txHoldingFull)
        else $error("holding full while tx off");
    chk_one_no_set: assert property (stWr && txHoldingFull && txEnable && !txLoad
        |=> txHoldingFull) else $error("write set empty flag");
    chk_rearm_needed: assert property (stWr && $past(stWr) && txEnable && !txLoad
        |=> txHoldingFull == $past(txHoldingFull)) else $error("clear without read");
    chk_addr_send: assert property (stWr |=> txAddrBit == $past(regWrData[SSPF_BIT_ATX]))
        else $error("send address bit wrong");
    chk_enable_write: assert property (ctlWr |=> txEnable == $past(regWrData[SSPF_CTL_TXEN])
        && rxEnable == $past(regWrData[SSPF_CTL_RXEN])) else $error("enable bits wrong");
    chk_done_gate: assert property (ctlWr && !regWrData[SSPF_CTL_TDIE] |=> !txDoneIrq)
        else $error("done request not gated");
    chk_off_flags: assert property (regRdStb && regAddr == SSPF_ADDR_STATUS && !txEnable
        && !$past(txEnable) |=> regRdData[SSPF_BIT_TCO] && regRdData[SSPF_BIT_TDE])
        else $error("flags not set while tx off");
    cover property (txLoad && txEnable);
    cover property (stWr && !regWrData[SSPF_BIT_TDE]);
    cover property (txDoneIrq);
endmodule

bind serial_status_flag_logic sspf_chk u_chk (.*);

// ===== sspf_rx_decide.sv
/*
 Classifies each completed reception: accepted, or skipped by the
 address filter.
 Assumes: rxDone is a one-cycle pulse with its side bits valid alongside.
*/
module sspf_rx_decide
    import sspf_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic rxDone,
    input wire logic rxAddrBit,
    input wire logic filterOn,
    output logic accept,
    output logic skip,
    output logic filterRelease
);
    typedef struct packed {
        sspf_rxdec_t dec;
    } sspf_dec_st_t;
    sspf_dec_st_t st_r, st_nxt;

    always_comb begin
        st_nxt = st_r;
        accept = 1'b0;
        skip = 1'b0;
        filterRelease = 1'b0;
        case (st_r.dec)
            SSPF_RX_IDLE,
            SSPF_RX_ACCEPT,
            SSPF_RX_SKIP: begin
                st_nxt.dec = SSPF_RX_IDLE;
                if (rxDone) begin
                    if (filterOn && !rxAddrBit) begin
                        skip = 1'b1; // RULE14
                        st_nxt.dec = SSPF_RX_SKIP;
                    end else begin
                        accept = 1'b1;
                        filterRelease = filterOn; // RULE14
                        st_nxt.dec = SSPF_RX_ACCEPT;
                    end
                end
            end
            default: begin
                st_nxt.dec = SSPF_RX_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{dec: SSPF_RX_IDLE};
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
